// ==== verilog/isd_pkg.sv ====
// Package of register map, field layout and timing constants for isd block
package isd_pkg;
    // Register byte addresses on the AHB-Lite bus
    localparam logic [7:0] ADDR_INT_SOURCE = 8'h00;
    localparam logic [7:0] ADDR_CLOCK_PRESCALE = 8'h04;
    localparam logic [7:0] ADDR_SCL_LOW_DIVIDER = 8'h08;
    localparam logic [7:0] ADDR_SCL_HIGH_DIVIDER = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_ENABLE = 8'h14;
    localparam logic [7:0] ADDR_MODE = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
    // Field positions
    localparam int CODE_LSB = 0;
    localparam int CODE_MSB = 2;
    localparam int RSVD_RW_LSB = 8;
    localparam int RSVD_RW_MSB = 11;
    localparam int PRESCALE_MSB = 7;
    localparam int MODE_RUN_BIT = 0;
    localparam int MODE_MASTER_BIT = 1;
    localparam int NUM_EVENTS = 7;
    // Reset values
    localparam logic [15:0] RESET_REG16 = 16'h0000;
    localparam logic [7:0] RESET_PRESCALE = 8'h00;
    localparam logic [6:0] RESET_EVENTS = 7'h00;
    // Offset d of each SCL half period, picked by prescale value
    localparam logic [3:0] OFFSET_PSC0 = 4'h7;
    localparam logic [3:0] OFFSET_PSC1 = 4'h6;
    localparam logic [3:0] OFFSET_PSCN = 4'h5;
    // Interrupt codes; event index i has code i+1
    typedef enum logic [2:0] {
        CODE_NONE = 3'h0,
        CODE_ARB_LOST = 3'h1,
        CODE_NACK = 3'h2,
        CODE_REG_READY = 3'h3,
        CODE_RX_READY = 3'h4,
        CODE_TX_READY = 3'h5,
        CODE_STOP = 3'h6,
        CODE_ADDRESSED = 3'h7
    } isd_code_t;
    // SCL generator states, Gray coded along idle-low-high
    typedef enum logic [1:0] {
        SCL_IDLE = 2'b00,
        SCL_LOW = 2'b01,
        SCL_HIGH = 2'b11
    } isd_scl_state_t;
endpackage

// ==== verilog/isd_scl_gen.sv ====
// SCL master clock generator from module clock ticks
`timescale 1ns/1ps
module isd_scl_gen
    import isd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic run, // Module out of reset
    input wire logic master, // Acting as bus master
    input wire logic tick, // One module clock period elapsed
    input wire logic [7:0] prescale, // Latched prescale value
    input wire logic [15:0] lowDiv,
    input wire logic [15:0] highDiv,
    output logic scl // Registered SCL level
);
    isd_scl_state_t state, next_state;
    logic [16:0] count, next_count; // Module clock periods left in phase
    logic next_scl;
    logic [3:0] offset; // Offset d
    logic [16:0] lowLen, highLen;

    // Offset d depends on the prescale value
    always_comb
    begin
        if (prescale == 8'h00)
            offset = OFFSET_PSC0;
        else if (prescale == 8'h01)
            offset = OFFSET_PSC1;
        else
            offset = OFFSET_PSCN;
        lowLen = {1'b0, lowDiv} + {13'h0000, offset};
        highLen = {1'b0, highDiv} + {13'h0000, offset};
    end

    // Phase sequencing; count loaded with length minus one
    always_comb
    begin
        next_state = state;
        next_count = count;
        next_scl = scl;
        case (state)
            SCL_IDLE:
            begin
                next_scl = 1'b1;
                if (run && master && tick)
                begin
                    next_state = SCL_LOW;
                    next_count = lowLen - 17'h00001;
                    next_scl = 1'b0;
                end
            end
            SCL_LOW:
            begin
                if (!run || !master)
                begin
                    next_state = SCL_IDLE;
                    next_scl = 1'b1;
                end
                else if (tick)
                begin
                    if (count == 17'h00000)
                    begin
                        next_state = SCL_HIGH;
                        next_count = highLen - 17'h00001;
                        next_scl = 1'b1;
                    end
                    else
                        next_count = count - 17'h00001;
                end
            end
            SCL_HIGH:
            begin
                if (!run || !master)
                    next_state = SCL_IDLE;
                else if (tick)
                begin
                    if (count == 17'h00000)
                    begin
                        next_state = SCL_LOW;
                        next_count = lowLen - 17'h00001;
                        next_scl = 1'b0;
                    end
                    else
                        next_count = count - 17'h00001;
                end
            end
            default:
            begin
                next_state = SCL_IDLE;
                next_scl = 1'b1;
            end
        endcase
    end

    // Register stage; SCL idles high (released)
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= SCL_IDLE;
            count <= 17'h00000;
            scl <= 1'b1;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            scl <= next_scl;
        end
    end

    // A low phase never ends before 5 clocks, the smallest offset d; dropping run
    // or master cuts a phase short on purpose, so that case is excused
    low_min_a: assert property (
        @(posedge clk_sys) disable iff (!rstn || !run || !master)
        $fell(scl) |-> !scl[*5])
        else $error("SCL low phase too short");
endmodule

// ==== verilog/isd_top.sv ====
// Interrupt source decoder and SCL divider with AHB-Lite registers
`timescale 1ns/1ps
module isd_top
    import isd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic debugRead, // Debugger access: reads have no side effect
    input wire logic [6:0] eventPulse, // Event sets, index i is code i+1
    output logic sclOut, // SCL drive low when 1
    output logic sclOe,
    output logic irq
);
    // Registers
    logic [3:0] rsvdRw, next_rsvdRw; // Bits 11-8 of interrupt_source
    logic [2:0] interrupt_code, next_interrupt_code;
    logic [7:0] prescale_value, next_prescale_value; // Software copy
    logic [7:0] activePrescale, next_activePrescale; // Used by dividers
    logic [15:0] low_time_divider, next_low_time_divider;
    logic [15:0] high_time_divider, next_high_time_divider;
    logic [6:0] status_register, next_status_register; // Event flags
    logic [6:0] enable, next_enable; // Interrupt enables
    logic module_run_enable, next_module_run_enable;
    logic masterMode, next_masterMode;
    logic [6:0] irqStatus, next_irqStatus;
    logic [6:0] irqMask, next_irqMask;
    logic [7:0] preCount, next_preCount; // Prescaler counter
    logic tick, next_tick; // Module clock tick
    logic next_irq, next_sclOut, next_sclOe;
    // Bus pipeline
    logic dWr, next_dWr;
    logic dRd, next_dRd;
    logic dDbg, next_dDbg;
    logic [7:0] dAddr, next_dAddr;
    logic [31:0] next_hrdata;
    logic sclLevel;
    logic [6:0] pend;
    logic [2:0] topCode;
    logic [6:0] clrFlags;
    logic [6:0] wrFlags;
    logic rdCode;

    // Highest-priority pending enabled event; lowest code wins
    always_comb
    begin
        pend = status_register & enable;
        topCode = CODE_NONE;
        for (int i = NUM_EVENTS - 1; i >= 0; i--)
            if (pend[i])
                topCode = 3'(i + 1);
    end

    // Address phase capture and register read/write effects
    always_comb
    begin
        next_dWr = hsel && hready && htrans[1] && hwrite;
        next_dRd = hsel && hready && htrans[1] && !hwrite;
        next_dDbg = debugRead;
        next_dAddr = (hsel && hready && htrans[1]) ? haddr : dAddr;
        rdCode = dRd && !dDbg && dAddr == ADDR_INT_SOURCE;
        next_rsvdRw = rsvdRw;
        next_prescale_value = prescale_value;
        next_low_time_divider = low_time_divider;
        next_high_time_divider = high_time_divider;
        next_enable = enable;
        next_module_run_enable = module_run_enable;
        next_masterMode = masterMode;
        next_irqMask = irqMask;
        wrFlags = 7'h00;
        if (dWr)
        begin
            case (dAddr)
                ADDR_INT_SOURCE:
                    next_rsvdRw = hwdata[RSVD_RW_MSB:RSVD_RW_LSB];
                ADDR_CLOCK_PRESCALE:
                    next_prescale_value = hwdata[PRESCALE_MSB:0];
                ADDR_SCL_LOW_DIVIDER:
                    next_low_time_divider = hwdata[15:0];
                ADDR_SCL_HIGH_DIVIDER:
                    next_high_time_divider = hwdata[15:0];
                ADDR_STATUS:
                    wrFlags = hwdata[6:0]; // Write one to clear
                ADDR_ENABLE:
                    next_enable = hwdata[6:0];
                ADDR_MODE:
                begin
                    next_module_run_enable = hwdata[MODE_RUN_BIT];
                    next_masterMode = hwdata[MODE_MASTER_BIT];
                end
                ADDR_IRQ_MASK:
                    next_irqMask = hwdata[6:0];
                default:
                    next_rsvdRw = rsvdRw; // Unmapped: ignored
            endcase
        end
        // Read of arbitration lost, NACK or stop code clears its flag
        clrFlags = wrFlags;
        if (rdCode && (interrupt_code == CODE_ARB_LOST
            || interrupt_code == CODE_NACK || interrupt_code == CODE_STOP))
            clrFlags[interrupt_code - 3'h1] = 1'b1;
        // Hardware set wins over a read or write-one clear in the same cycle; run-enable low clears all flags
        next_status_register = (status_register & ~clrFlags) | eventPulse;
        if (!module_run_enable)
            next_status_register = RESET_EVENTS;
        // Code: cleared by read, reloaded with next pending event
        if (rdCode)
            next_interrupt_code = CODE_NONE;
        else if (interrupt_code == CODE_NONE)
            next_interrupt_code = topCode;
        else
            next_interrupt_code = interrupt_code;
        if (!module_run_enable)
            next_interrupt_code = CODE_NONE;
        // Sticky interrupt status, write one clears, set wins
        next_irqStatus = irqStatus;
        if (dWr && dAddr == ADDR_IRQ_STATUS)
            next_irqStatus = irqStatus & ~hwdata[6:0];
        next_irqStatus = next_irqStatus | eventPulse;
        next_irq = |(next_irqStatus & next_irqMask);
        next_hrdata = 32'h00000000;
        if (next_dRd)
        begin
            case (haddr)
                ADDR_INT_SOURCE: // Reserved bits 15-12, 7-3 read zero
                    next_hrdata = {20'h00000, next_rsvdRw, 5'h00,
                        next_interrupt_code};
                ADDR_CLOCK_PRESCALE:
                    next_hrdata = {24'h000000, next_prescale_value};
                ADDR_SCL_LOW_DIVIDER:
                    next_hrdata = {16'h0000, next_low_time_divider};
                ADDR_SCL_HIGH_DIVIDER:
                    next_hrdata = {16'h0000, next_high_time_divider};
                ADDR_STATUS:
                    next_hrdata = {25'h0000000, next_status_register};
                ADDR_ENABLE:
                    next_hrdata = {25'h0000000, next_enable};
                ADDR_MODE:
                    next_hrdata = {30'h00000000, next_masterMode,
                        next_module_run_enable};
                ADDR_IRQ_STATUS:
                    next_hrdata = {25'h0000000, next_irqStatus};
                ADDR_IRQ_MASK:
                    next_hrdata = {25'h0000000, next_irqMask};
                default:
                    next_hrdata = 32'h00000000;
            endcase
        end
    end

    // Prescaler: latched only on run-enable rising edge
    always_comb
    begin
        next_activePrescale = activePrescale;
        if (next_module_run_enable && !module_run_enable)
            next_activePrescale = prescale_value;
        next_preCount = preCount;
        next_tick = 1'b0;
        if (!module_run_enable)
            next_preCount = 8'h00;
        else if (preCount == activePrescale)
        begin
            next_preCount = 8'h00;
            next_tick = 1'b1;
        end
        else
            next_preCount = preCount + 8'h01;
        next_sclOut = !sclLevel; // Open drain: drive low only
        next_sclOe = !sclLevel;
    end

    // Register stage for all state
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rsvdRw <= 4'h0;
            interrupt_code <= CODE_NONE;
            prescale_value <= RESET_PRESCALE;
            activePrescale <= RESET_PRESCALE;
            low_time_divider <= RESET_REG16;
            high_time_divider <= RESET_REG16;
            status_register <= RESET_EVENTS;
            enable <= RESET_EVENTS;
            module_run_enable <= 1'b0;
            masterMode <= 1'b0;
            irqStatus <= RESET_EVENTS;
            irqMask <= RESET_EVENTS;
            preCount <= 8'h00;
            tick <= 1'b0;
            dWr <= 1'b0;
            dRd <= 1'b0;
            dDbg <= 1'b0;
            dAddr <= 8'h00;
            hrdata <= 32'h00000000;
            irq <= 1'b0;
            sclOut <= 1'b0;
            sclOe <= 1'b0;
        end
        else
        begin
            rsvdRw <= next_rsvdRw;
            interrupt_code <= next_interrupt_code;
            prescale_value <= next_prescale_value;
            activePrescale <= next_activePrescale;
            low_time_divider <= next_low_time_divider;
            high_time_divider <= next_high_time_divider;
            status_register <= next_status_register;
            enable <= next_enable;
            module_run_enable <= next_module_run_enable;
            masterMode <= next_masterMode;
            irqStatus <= next_irqStatus;
            irqMask <= next_irqMask;
            preCount <= next_preCount;
            tick <= next_tick;
            dWr <= next_dWr;
            dRd <= next_dRd;
            dDbg <= next_dDbg;
            dAddr <= next_dAddr;
            hrdata <= next_hrdata;
            irq <= next_irq;
            sclOut <= next_sclOut;
            sclOe <= next_sclOe;
        end
    end

    // Zero-wait slave, always OKAY
    always_comb
    begin
        hreadyout = 1'b1;
        hresp = 1'b0;
    end

    // Master SCL shaping from module clock ticks
    isd_scl_gen u_scl (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .run(module_run_enable),
        .master(masterMode),
        .tick(tick),
        .prescale(activePrescale),
        .lowDiv(low_time_divider),
        .highDiv(high_time_divider),
        .scl(sclLevel)
    );

    code_clear_a: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        rdCode |=> interrupt_code == CODE_NONE)
        else $error("Code not cleared by read");
    flag_clear_a: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        rdCode && interrupt_code == CODE_ARB_LOST && !eventPulse[0]
        |=> !status_register[0])
        else $error("Arbitration flag not cleared");
    debug_keep_a: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        dRd && dDbg && interrupt_code != CODE_NONE && module_run_enable
        && $stable(module_run_enable)
        |=> $stable(interrupt_code))
        else $error("Debugger read changed code");
    reload_a: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        interrupt_code == CODE_NONE && !rdCode && module_run_enable
        && pend[0] |=> interrupt_code == CODE_ARB_LOST)
        else $error("Pending code not loaded");
    psc_hold_a: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        module_run_enable && $past(module_run_enable)
        |-> $stable(activePrescale))
        else $error("Prescale changed while running");
    // Run-enable falling stops the ticks mid-pattern, which is legal
    tick_rate_a: assert property (
        @(posedge clk_sys) disable iff (!rstn || !module_run_enable)
        tick && activePrescale == 8'h01 && module_run_enable
        |=> !tick ##1 tick)
        else $error("Module clock rate wrong");
    rsvd_zero_a: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        dRd && dAddr == ADDR_INT_SOURCE |-> hrdata[7:3] == 5'h00
        && hrdata[15:12] == 4'h0)
        else $error("Reserved bits nonzero");
    scl_slave_a: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        !masterMode |-> ##2 !sclOe)
        else $error("SCL driven while not master");
endmodule

// ==== testbench/isd_bus_model.sv ====
// Far side of the SCL wire: pull-up plus a listener timing each span
`timescale 1ns/1ps
module isd_bus_model (
    input wire logic clk_sys,
    input wire logic sclOut, // Master pulls the line low when set
    input wire logic sclOe, // Master drives the line
    output logic sclLine, // Resolved wire level
    output int lowLen, // Last completed low span, in clocks
    output int highLen // Last completed high span, in clocks
);
    int runLen = 0; // Clocks since the last line edge
    logic lastLine = 1'b1; // Line level seen at the previous edge
    // Released line floats up through the pull-up, never holds old data
    assign sclLine = (sclOe === 1'b1 && sclOut === 1'b1) ? 1'b0 : 1'b1;
    // Span timer; a span is recorded only when it ends, so a stalled
    // clock leaves the old figure rather than a partial count
    always @(posedge clk_sys)
    begin
        lastLine <= sclLine;
        runLen <= runLen + 1;
        if (sclLine !== lastLine)
        begin
            runLen <= 1;
            // Close the span that just ended
            if (lastLine === 1'b0)
                lowLen <= runLen;
            else
                highLen <= runLen;
        end
    end
endmodule

// ==== testbench/isd_top_tb.sv ====
// Self-checking bench for the interrupt decoder and SCL divider
`timescale 1ns/1ps
module isd_top_tb
    import isd_pkg::*;
;
    logic clk_sys, rstn, hsel, hwrite, hready, debugRead;
    logic [7:0] haddr; // Byte address
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic hreadyout, hresp, sclOut, sclOe, irq, sclLine;
    logic [6:0] eventPulse; // Event set strobes
    int lowLen, highLen; // Spans seen by the bus model
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0; // Timeout counter
    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    isd_top dut (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .debugRead(debugRead),
        .eventPulse(eventPulse), .sclOut(sclOut), .sclOe(sclOe),
        .irq(irq));
    isd_bus_model model (.clk_sys(clk_sys), .sclOut(sclOut),
        .sclOe(sclOe), .sclLine(sclLine), .lowLen(lowLen),
        .highLen(highLen));
    // Clock, 5 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Verdict and end of run
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Ceiling well above the few thousand cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
    // Compare with case equality so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // One AHB-Lite single word transfer; entered just after an edge
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, input logic dbg, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        debugRead <= dbg;
        @(posedge clk_sys);
        // Address phase holds until ready is seen high
        while (hready !== 1'b1) @(posedge clk_sys);
        htrans <= 2'b00;
        hsel <= 1'b0;
        debugRead <= 1'b0;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] junk;
        bus(1'b1, a, d, 1'b0, junk);
    endtask
    // Read and compare; dbg marks a debugger access
    task automatic rdc(input logic [7:0] a, input logic dbg,
        input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 32'h0000_0000, dbg, d);
        chk(d, exp);
    endtask
    // Pulse events for one cycle, then let the code settle
    task automatic ev(input logic [6:0] m);
        eventPulse <= m;
        @(posedge clk_sys);
        eventPulse <= 7'h00;
        idle(3);
    endtask
    task automatic t_regs();
        rdc(ADDR_INT_SOURCE, 1'b0, 32'h0000_0000);
        rdc(ADDR_CLOCK_PRESCALE, 1'b0, 32'h0000_0000);
        // The slave must always answer OKAY
        chk(32'(hresp), 32'h0000_0000);
        wr(8'h24, 32'hffff_ffff);
        rdc(8'h24, 1'b0, 32'h0000_0000);
        wr(ADDR_INT_SOURCE, 32'hffff_f0ff);
        rdc(ADDR_INT_SOURCE, 1'b0, 32'h0000_0000);
        wr(ADDR_CLOCK_PRESCALE, 32'h0000_ffff);
        rdc(ADDR_CLOCK_PRESCALE, 1'b0, 32'h0000_00ff);
        wr(ADDR_SCL_LOW_DIVIDER, 32'h0000_abcd);
        rdc(ADDR_SCL_LOW_DIVIDER, 1'b0, 32'h0000_abcd);
        wr(ADDR_SCL_HIGH_DIVIDER, 32'h0000_5a3c);
        rdc(ADDR_SCL_HIGH_DIVIDER, 1'b0, 32'h0000_5a3c);
    endtask
    // Each event alone gives its own code; run off clears it again
    task automatic t_codes();
        wr(ADDR_ENABLE, 32'h0000_007f);
        for (int i = 0; i < NUM_EVENTS; i++)
        begin
            wr(ADDR_MODE, 32'h0000_0001);
            ev(7'(1 << i));
            rdc(ADDR_INT_SOURCE, 1'b0, 32'(i + 1));
            wr(ADDR_MODE, 32'h0000_0000);
        end
    endtask
    // Several pending, one disabled; debugger read has no side effect
    task automatic t_priority();
        wr(ADDR_MODE, 32'h0000_0001);
        wr(ADDR_ENABLE, 32'h0000_007b);
        ev(7'h27);
        rdc(ADDR_INT_SOURCE, 1'b1, 32'h0000_0001);
        rdc(ADDR_STATUS, 1'b0, 32'h0000_0027);
        rdc(ADDR_INT_SOURCE, 1'b0, 32'h0000_0001);
        idle(2);
        rdc(ADDR_STATUS, 1'b0, 32'h0000_0026);
        rdc(ADDR_INT_SOURCE, 1'b0, 32'h0000_0002);
        idle(2);
        rdc(ADDR_INT_SOURCE, 1'b0, 32'h0000_0006);
        idle(2);
        rdc(ADDR_STATUS, 1'b0, 32'h0000_0004);
        rdc(ADDR_INT_SOURCE, 1'b0, 32'h0000_0000);
        // Disabled flag left behind is cleared by writing one
        wr(ADDR_STATUS, 32'h0000_0004);
        rdc(ADDR_STATUS, 1'b0, 32'h0000_0000);
        wr(ADDR_MODE, 32'h0000_0000);
    endtask
    // Interrupt line: masked, unmasked, then cleared by writing one
    task automatic t_irq();
        wr(ADDR_MODE, 32'h0000_0001);
        wr(ADDR_IRQ_MASK, 32'h0000_0000);
        // Earlier tests left sticky bits set; start from a clean slate
        wr(ADDR_IRQ_STATUS, 32'h0000_007f);
        rdc(ADDR_IRQ_STATUS, 1'b0, 32'h0000_0000);
        ev(7'h02);
        chk(32'(irq), 32'h0000_0000);
        rdc(ADDR_IRQ_STATUS, 1'b0, 32'h0000_0002);
        wr(ADDR_IRQ_MASK, 32'h0000_0002);
        idle(2);
        chk(32'(irq), 32'h0000_0001);
        wr(ADDR_IRQ_STATUS, 32'h0000_0002);
        idle(2);
        chk(32'(irq), 32'h0000_0000);
        wr(ADDR_MODE, 32'h0000_0000);
    endtask
    // Let several SCL periods pass, then compare the last spans
    task automatic meas(input int lo, input int hi);
        idle(6 * (lo + hi));
        chk(32'(lowLen), 32'(lo));
        chk(32'(highLen), 32'(hi));
    endtask
    // Program dividers while held in reset, then run as master
    task automatic cfg(input logic [7:0] p, input logic [15:0] l,
        input logic [15:0] h);
        wr(ADDR_MODE, 32'h0000_0000);
        wr(ADDR_CLOCK_PRESCALE, {24'h0, p});
        wr(ADDR_SCL_LOW_DIVIDER, {16'h0, l});
        wr(ADDR_SCL_HIGH_DIVIDER, {16'h0, h});
        wr(ADDR_MODE, 32'h0000_0003);
    endtask
    task automatic t_scl();
        logic bad;
        bad = 1'b0;
        cfg(8'h02, 16'h0001, 16'h0002);
        meas(18, 21);
        wr(ADDR_CLOCK_PRESCALE, 32'h0000_0000);
        meas(18, 21);
        wr(ADDR_MODE, 32'h0000_0000);
        wr(ADDR_MODE, 32'h0000_0003);
        meas(8, 9);
        cfg(8'h01, 16'h0001, 16'h0001);
        meas(14, 14);
        cfg(8'h13, 16'h0001, 16'h0002);
        meas(120, 140);
        // Run without master role: the line must stay released
        wr(ADDR_MODE, 32'h0000_0001);
        // Two register stages lie between the mode bit and the pin
        idle(2);
        repeat (100)
        begin
            @(posedge clk_sys);
            if (sclOe !== 1'b0)
                bad = 1'b1;
        end
        chk(32'(bad), 32'h0000_0000);
        wr(ADDR_MODE, 32'h0000_0000);
    endtask
    // Main sequence
    initial
    begin
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        debugRead = 1'b0;
        eventPulse = 7'h00;
        idle(10);
        rstn <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_codes();
        t_priority();
        t_irq();
        t_scl();
        wrap_up();
    end
endmodule
